/* File: pkg/uht_pkg.sv */
// Purpose: Shared constants and types for the token and frame register slice
// Assumes: 100 MHz module clock, full-speed bit rate of 12 Mb/s
// Notes: Byte offsets on an 8-bit register address
package uht_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_FUNC_ADDR = 8'h98;
    localparam logic [7:0] OFS_TBL_LOW = 8'h9C;
    localparam logic [7:0] OFS_FRM_LOW = 8'hA0;
    localparam logic [7:0] OFS_FRM_HIGH = 8'hA4;
    localparam logic [7:0] OFS_TOKEN = 8'hA8;
    localparam logic [7:0] OFS_GUARD = 8'hAC;
    localparam logic [7:0] OFS_TBL_MID = 8'hB0;
    localparam logic [7:0] OFS_TBL_HIGH = 8'hB4;
    localparam logic [7:0] OFS_STATUS = 8'hB8;
    // Field positions
    localparam int LOW_SPEED_BIT = 7;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_GUARD_BIT = 1;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [10:0] RST_FRAME = 11'h000;
    // Token kinds
    localparam logic [3:0] KIND_OUT = 4'h1;
    localparam logic [3:0] KIND_IN = 4'h9;
    localparam logic [3:0] KIND_SETUP = 4'hD;
    // Frame timing: 1 ms of 12 Mb/s bit times
    localparam int FRAME_TIME_US = 1000;
    localparam int BIT_RATE_MHZ = 12;
    localparam int CLK_RATE_MHZ = 100;
    localparam logic [13:0] SOF_RELOAD =
        14'(FRAME_TIME_US * BIT_RATE_MHZ);
    localparam logic [6:0] PH_STEP = 7'(BIT_RATE_MHZ);
    localparam logic [6:0] PH_WRAP = 7'(CLK_RATE_MHZ);
    localparam int BYTE_SHIFT = 3;

    typedef enum logic [1:0] {ST_IDLE, ST_PEND, ST_RUN} uht_state_t;

    // Token request handed to the packet engine
    typedef struct packed {
        logic [3:0] kind;
        logic [3:0] endpoint;
        logic [6:0] func_addr;
        logic low_speed;
        logic [7:0] ep0_ctrl;
        logic is_tx;
    } uht_tok_t;

    // Token seen on the bus in peripheral role
    typedef struct packed {
        logic valid;
        logic [6:0] func_addr;
    } uht_rx_tok_t;
endpackage

/* File: logic/uht_regs.sv */
// Purpose: Address, table base, frame number, token issue and SOF timing
// Assumes: Synchronous inputs; packet engine answers each token with done
// Notes: Read data stand one cycle after the read strobe
//
// Overview of operation
// - Match tokens on address; send address in host
// - Address clears on reset and bus reset
// - Address use only while module enabled
// - Low-speed flag makes next token low speed
// - Table page low holds base bits 15:9
// - Table page mid holds base bits 23:16
// - Table page high holds base bits 31:24
// - Eleven-bit frame number split over two registers
// - Token write starts transaction in host role
// - Endpoint zero control steers handshake and retry
// - Token kinds OUT, IN, SETUP decoded
// - Fourteen-bit SOF counter, reload 12000, host only
// - No tokens start below threshold until SOF
// - Busy flag set while token executes
// - Host role when host select is one
module uht_regs (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_host_role_select,
    input wire logic i_module_en,
    input wire logic i_usb_bus_reset,
    input wire logic [7:0] i_endpoint_zero_ctrl,
    input wire uht_pkg::uht_rx_tok_t i_rx_tok,
    input wire logic i_rx_sof,
    input wire logic [10:0] i_rx_frame,
    input wire logic i_tok_done,
    output logic [7:0] o_rdata,
    output logic o_addr_match,
    output logic o_tok_start,
    output uht_pkg::uht_tok_t o_tok,
    output logic o_token_busy,
    output logic o_sof_start,
    output logic [10:0] o_frame_count,
    output logic [31:0] o_descriptor_table_base
);
    import uht_pkg::*;

    logic [7:0] func_addr_q;
    logic [6:0] tbl_low_q;
    logic [7:0] tbl_mid_q, tbl_high_q, token_q, guard_q;
    logic [10:0] frame_q;
    logic [13:0] sof_cnt_q;
    logic [6:0] phase_q;
    logic guard_hit_q;
    uht_state_t state_q, state_d;
    uht_tok_t tok_q;
    logic tok_start_q, sof_q, match_q;
    logic [7:0] rdata_q;

    // Access decode
    wire host_on = i_host_role_select && i_module_en;
    wire wr_addr = i_wr && (i_addr == OFS_FUNC_ADDR);
    wire wr_tlow = i_wr && (i_addr == OFS_TBL_LOW);
    wire wr_tmid = i_wr && (i_addr == OFS_TBL_MID);
    wire wr_thigh = i_wr && (i_addr == OFS_TBL_HIGH);
    wire wr_tok = i_wr && (i_addr == OFS_TOKEN);
    wire wr_guard = i_wr && (i_addr == OFS_GUARD);

    // Token kind decode; unknown kinds are ignored
    wire [3:0] wkind = i_wdata[7:4];
    wire kind_ok = (wkind == KIND_OUT) || (wkind == KIND_IN)
        || (wkind == KIND_SETUP);
    wire wkind_tx = (wkind != KIND_IN);
    wire tok_accept = wr_tok && host_on && kind_ok
        && (state_q == ST_IDLE);

    // Bit-time tick from a fractional phase accumulator
    wire [6:0] phase_sum = phase_q + PH_STEP;
    wire bit_tick = (phase_sum >= PH_WRAP);
    wire sof_due = host_on && bit_tick && (sof_cnt_q == 14'h0000);
    wire [13:0] cnt_bytes = sof_cnt_q >> BYTE_SHIFT;
    wire below_guard = (cnt_bytes <= {6'h00, guard_q});
    wire may_start = (state_q == ST_PEND) && !guard_hit_q
        && !below_guard && !sof_due;

    // Read selection
    wire [7:0] rd_mux =
        (i_addr == OFS_FUNC_ADDR) ? func_addr_q :
        (i_addr == OFS_TBL_LOW) ? {tbl_low_q, 1'b0} :
        (i_addr == OFS_FRM_LOW) ? frame_q[7:0] :
        (i_addr == OFS_FRM_HIGH) ? {5'h00, frame_q[10:8]} :
        (i_addr == OFS_TOKEN) ? token_q :
        (i_addr == OFS_GUARD) ? guard_q :
        (i_addr == OFS_TBL_MID) ? tbl_mid_q :
        (i_addr == OFS_TBL_HIGH) ? tbl_high_q :
        (i_addr == OFS_STATUS) ? {6'h00, guard_hit_q,
            (state_q != ST_IDLE)} : 8'h00;

    // Function address with low-speed flag
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || i_usb_bus_reset)
            func_addr_q <= RST_BYTE;
        else if (wr_addr)
            func_addr_q <= i_wdata;
    end

    // Table base pages and guard threshold
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            tbl_low_q <= 7'h00;
            tbl_mid_q <= RST_BYTE;
            tbl_high_q <= RST_BYTE;
            guard_q <= RST_BYTE;
        end
        else
        begin
            if (wr_tlow)
                tbl_low_q <= i_wdata[7:1];
            if (wr_tmid)
                tbl_mid_q <= i_wdata;
            if (wr_thigh)
                tbl_high_q <= i_wdata;
            if (wr_guard)
                guard_q <= i_wdata;
        end
    end

    // Token register keeps the last accepted command
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            token_q <= RST_BYTE;
        else if (tok_accept)
            token_q <= i_wdata;
    end

    // Token state: pending until guard clears, running until done
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (tok_accept)
                    state_d = ST_PEND;
            ST_PEND:
                if (!host_on)
                    state_d = ST_IDLE;
                else if (may_start)
                    state_d = ST_RUN;
            ST_RUN:
                if (i_tok_done || !host_on)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // Request capture: address, speed and endpoint zero policy
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            tok_q <= '0;
        else if (tok_accept)
        begin
            tok_q.kind <= wkind;
            tok_q.endpoint <= i_wdata[3:0];
            tok_q.func_addr <= func_addr_q[6:0];
            tok_q.low_speed <= func_addr_q[LOW_SPEED_BIT];
            tok_q.ep0_ctrl <= i_endpoint_zero_ctrl;
            tok_q.is_tx <= wkind_tx;
        end
    end

    // Start pulse and busy flag
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            tok_start_q <= 1'b0;
            o_token_busy <= 1'b0;
        end
        else
        begin
            tok_start_q <= may_start && host_on;
            o_token_busy <= (state_d != ST_IDLE);
        end
    end

    // SOF interval counter in bit times
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || !host_on)
        begin
            phase_q <= 7'h00;
            sof_cnt_q <= SOF_RELOAD;
        end
        else if (bit_tick)
        begin
            phase_q <= phase_sum - PH_WRAP;
            if (sof_cnt_q == 14'h0000)
                sof_cnt_q <= SOF_RELOAD;
            else
                sof_cnt_q <= sof_cnt_q - 14'h0001;
        end
        else
            phase_q <= phase_sum;
    end

    // Guard window closes token starts until SOF goes out
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || !host_on || sof_due)
            guard_hit_q <= 1'b0;
        else if (below_guard)
            guard_hit_q <= 1'b1;
    end

    // SOF pulse and frame number
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            sof_q <= 1'b0;
            frame_q <= RST_FRAME;
        end
        else
        begin
            sof_q <= sof_due;
            if (sof_due)
                frame_q <= frame_q + 11'h001;
            else if (!i_host_role_select && i_module_en && i_rx_sof)
                frame_q <= i_rx_frame;
        end
    end

    // Peripheral address match
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            match_q <= 1'b0;
        else
            match_q <= i_rx_tok.valid && i_module_en
                && !i_host_role_select
                && (i_rx_tok.func_addr == func_addr_q[6:0]);
    end

    // Read data one cycle after the strobe
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            rdata_q <= RST_BYTE;
        else
            rdata_q <= i_rd ? rd_mux : RST_BYTE;
    end

    assign o_rdata = rdata_q;
    assign o_addr_match = match_q;
    assign o_tok_start = tok_start_q;
    assign o_tok = tok_q;
    assign o_sof_start = sof_q;
    assign o_frame_count = frame_q;
    assign o_descriptor_table_base =
        {tbl_high_q, tbl_mid_q, tbl_low_q, 9'h000};

    // Checks
    property p_addr_clr;
        @(posedge i_mclk) i_usb_bus_reset |=> func_addr_q == 8'h00;
    endproperty
    a_addr_clr: assert property (p_addr_clr)
        else $error("address not cleared by bus reset");
    property p_match_en;
        @(posedge i_mclk) disable iff (i_srst)
        !i_module_en |=> !o_addr_match;
    endproperty
    a_match_en: assert property (p_match_en)
        else $error("address matched while disabled");
    property p_match_ok;
        @(posedge i_mclk) disable iff (i_srst)
        o_addr_match |-> $past(i_rx_tok.func_addr) == $past(func_addr_q[6:0]);
    endproperty
    a_match_ok: assert property (p_match_ok)
        else $error("match on wrong address");
    property p_tok_busy;
        @(posedge i_mclk) disable iff (i_srst)
        tok_accept |=> o_token_busy;
    endproperty
    a_tok_busy: assert property (p_tok_busy)
        else $error("busy not raised on token");
    property p_no_host;
        @(posedge i_mclk) disable iff (i_srst)
        !i_host_role_select |=> !o_tok_start && !o_token_busy;
    endproperty
    a_no_host: assert property (p_no_host)
        else $error("token activity outside host role");
    property p_guard;
        @(posedge i_mclk) disable iff (i_srst)
        (guard_hit_q || below_guard) |=> !o_tok_start;
    endproperty
    a_guard: assert property (p_guard)
        else $error("token started inside guard window");
    property p_sof_reload;
        @(posedge i_mclk) disable iff (i_srst)
        sof_due |=> sof_cnt_q == SOF_RELOAD && o_sof_start;
    endproperty
    a_sof_reload: assert property (p_sof_reload)
        else $error("counter not reloaded at SOF");
    property p_frame_inc;
        @(posedge i_mclk) disable iff (i_srst)
        sof_due |=> o_frame_count == $past(o_frame_count) + 11'h001;
    endproperty
    a_frame_inc: assert property (p_frame_inc)
        else $error("frame number not advanced");
    property p_low_speed;
        @(posedge i_mclk) disable iff (i_srst)
        tok_accept |=> o_tok.low_speed == $past(func_addr_q[7]);
    endproperty
    a_low_speed: assert property (p_low_speed)
        else $error("low-speed flag not captured");

    c_tok: cover property (@(posedge i_mclk) tok_accept ##[1:200] o_tok_start);
    c_sof: cover property (@(posedge i_mclk) o_sof_start);
    c_match: cover property (@(posedge i_mclk) o_addr_match);
    c_guard: cover property (@(posedge i_mclk) guard_hit_q && o_token_busy);
endmodule

/* File: verification/uht_peer_model.sv */
// Purpose: Packet engine stand-in that finishes each started token
// Assumes: One token runs at a time; start is a one-cycle pulse
// Notes: Delay input lets the bench choose prompt or slow completion
module uht_peer_model (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_tok_start,
    input wire logic [7:0] i_delay,
    output logic o_tok_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    logic run_q;

    // Count down from the chosen delay, then pulse done once
    always_ff @(posedge i_mclk)
    begin
        o_tok_done <= 1'b0;
        if (i_srst)
        begin
            run_q <= 1'b0;
            cnt_q <= 8'h00;
        end
        else if (i_tok_start)
        begin
            run_q <= 1'b1;
            cnt_q <= i_delay;
        end
        else if (run_q && cnt_q == 8'h00)
        begin
            run_q <= 1'b0;
            o_tok_done <= 1'b1;
        end
        else if (run_q)
            cnt_q <= cnt_q - 8'h01;
    end
endmodule

/* File: verification/uht_regs_tb_top.sv */
// Purpose: Self-checking bench for the token and frame register slice
// Assumes: Peer model completes tokens; bench plays software and bus
// Notes: SOF itself is out of reach; the guard window is hit once at the end
module uht_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import uht_pkg::*;
    logic i_mclk = 1'b0;
    logic i_srst = 1'b1;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, ep0 = 8'h4D, dly = 8'h01;
    logic i_wr = 1'b0, i_rd = 1'b0, host = 1'b0, en = 1'b0;
    logic bus_rst = 1'b0, rx_sof = 1'b0;
    logic [10:0] rx_frame = 11'h000;
    uht_rx_tok_t rx_tok = '0;
    logic [7:0] rdata;
    logic match, tok_start, busy, sof, tok_done;
    uht_tok_t tok;
    logic [10:0] frame;
    logic [31:0] tbl;
    int errors = 0;
    int n_compared = 0;
    time t0;
    int dt = 0;
    int seen = 0;
    logic [7:0] st;
    // Cycles from host start until the counter enters the largest guard
    localparam logic [7:0] GUARD_MAX = 8'hFF;
    localparam int GUARD_CYC = (int'(SOF_RELOAD)
        - ((int'(GUARD_MAX) + 1) << BYTE_SHIFT) + 1)
        * CLK_RATE_MHZ / BIT_RATE_MHZ;
    logic [3:0] kinds [3] = '{KIND_OUT, KIND_IN, KIND_SETUP};

    // Free-running 100 MHz clock
    always #5 i_mclk = ~i_mclk;

    uht_regs i_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_host_role_select(host), .i_module_en(en),
        .i_usb_bus_reset(bus_rst), .i_endpoint_zero_ctrl(ep0),
        .i_rx_tok(rx_tok), .i_rx_sof(rx_sof), .i_rx_frame(rx_frame),
        .i_tok_done(tok_done), .o_rdata(rdata), .o_addr_match(match),
        .o_tok_start(tok_start), .o_tok(tok), .o_token_busy(busy),
        .o_sof_start(sof), .o_frame_count(frame),
        .o_descriptor_table_base(tbl));

    uht_peer_model i_peer (.i_mclk(i_mclk), .i_srst(i_srst),
        .i_tok_start(tok_start), .i_delay(dly), .o_tok_done(tok_done));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    // Write: one strobe cycle, then one idle edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(posedge i_mclk);
    endtask

    // Read: data sampled mid-cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        d = rdata;
        @(posedge i_mclk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk({24'h0, v}, {24'h0, e});
    endtask

    // Received token in peripheral role, match expected or not
    task automatic rx_chk(input logic [6:0] a, input logic e);
        rx_tok <= '{1'b1, a};
        @(posedge i_mclk);
        rx_tok <= '0;
        @(negedge i_mclk);
        chk(32'(match), 32'(e));
        @(posedge i_mclk);
    endtask

    // Poll status until the token engine is idle
    task automatic wait_idle();
        logic [7:0] s;
        s = 8'h01;
        for (int i = 0; i < 50 && s[STAT_BUSY_BIT] !== 1'b0; i++)
            rd(OFS_STATUS, s);
        chk(32'(s[STAT_BUSY_BIT]), 32'h0);
    endtask

    // Issue one token and check the request handed downstream
    task automatic tok_run(input logic [3:0] k, input logic [3:0] ep);
        uht_tok_t e;
        e = '{k, ep, 7'h25, 1'b1, 8'h4D, k != KIND_IN};
        wait_idle();
        wr(OFS_TOKEN, {k, ep});
        @(negedge i_mclk);
        for (int i = 0; i < 20 && tok_start !== 1'b1; i++)
            @(negedge i_mclk);
        chk(32'(tok_start), 32'h1);
        chk(32'(busy), 32'h1);
        chk(32'(tok), 32'(e));
        @(posedge i_mclk);
        wait_idle();
    endtask

    // A token write that must be ignored
    task automatic tok_bad(input logic [7:0] d);
        wr(OFS_TOKEN, d);
        @(negedge i_mclk);
        chk(32'(busy), 32'h0);
        @(posedge i_mclk);
    endtask

    task automatic conclude();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (10) @(posedge i_mclk);
        i_srst <= 1'b0;
        rchk(OFS_FUNC_ADDR, 8'h00);
        rchk(OFS_FRM_HIGH, 8'h00);
        rchk(8'h00, 8'h00);
        wr(OFS_FUNC_ADDR, 8'hA5);
        rchk(OFS_FUNC_ADDR, 8'hA5);
        i_srst <= 1'b1;
        @(posedge i_mclk);
        i_srst <= 1'b0;
        rchk(OFS_FUNC_ADDR, 8'h00);
        wr(OFS_FUNC_ADDR, 8'hA5);
        bus_rst <= 1'b1;
        @(posedge i_mclk);
        bus_rst <= 1'b0;
        rchk(OFS_FUNC_ADDR, 8'h00);
        wr(OFS_TBL_LOW, 8'hFF);
        wr(OFS_TBL_MID, 8'h12);
        wr(OFS_TBL_HIGH, 8'h34);
        rchk(OFS_TBL_LOW, 8'hFE);
        rchk(OFS_TBL_MID, 8'h12);
        rchk(OFS_TBL_HIGH, 8'h34);
        chk(tbl, 32'h3412FE00);
        wr(OFS_GUARD, 8'h4A);
        rchk(OFS_GUARD, 8'h4A);
        wr(OFS_FUNC_ADDR, 8'hA5);
        rx_chk(7'h25, 1'b0);
        en <= 1'b1;
        rx_chk(7'h25, 1'b1);
        rx_chk(7'h26, 1'b0);
        rx_frame <= 11'h5A3;
        rx_sof <= 1'b1;
        @(posedge i_mclk);
        rx_sof <= 1'b0;
        @(posedge i_mclk);
        rchk(OFS_FRM_LOW, 8'hA3);
        rchk(OFS_FRM_HIGH, 8'h05);
        chk(32'(frame), 32'h5A3);
        host <= 1'b1;
        rx_chk(7'h25, 1'b0);
        tok_bad(8'h23);
        for (int j = 0; j < 3; j++)
        begin
            dly <= (j == 1) ? 8'h14 : 8'h01;
            tok_run(kinds[j], 4'(j + 1));
        end
        en <= 1'b0;
        tok_bad(8'h10);
        host <= 1'b0;
        en <= 1'b1;
        tok_bad(8'h10);
        // Guard window with the threshold at its largest value
        wr(OFS_GUARD, GUARD_MAX);
        host <= 1'b1;
        t0 = $time;
        st = 8'h00;
        for (int i = 0; i < 45000 && st[STAT_GUARD_BIT] !== 1'b1; i++)
            rd(OFS_STATUS, st);
        dt = int'(($time - t0) / 10) - GUARD_CYC;
        chk(32'(st[STAT_GUARD_BIT]), 32'h1);
        chk(32'(dt > -40 && dt < 40), 32'h1);
        chk(32'(sof), 32'h0);
        wr(OFS_TOKEN, {KIND_OUT, 4'h2});
        seen = 0;
        repeat (200)
        begin
            @(negedge i_mclk);
            if (tok_start !== 1'b0)
                seen++;
        end
        chk(32'(seen), 32'h0);
        chk(32'(busy), 32'h1);
        conclude();
    end

    // Watchdog beyond the guard wait of about 83000 cycles
    initial
    begin
        #950000;
        errors++;
        conclude();
    end
endmodule
